// >>> inc/nvm_params.svh
// Constants for the data EEPROM access controller.
`ifndef NVM_PARAMS_SVH
`define NVM_PARAMS_SVH
`define NVM_DATA_OFS 8'h08
`define NVM_ADDR_OFS 8'h09
`define NVM_CTRL_OFS 8'h88
`define NVM_UNLOCK_OFS 8'h89
`define NVM_BIT_DONE 4
`define NVM_BIT_ABORT 3
`define NVM_BIT_PERMIT 2
`define NVM_BIT_GO 1
`define NVM_BIT_FETCH 0
`define NVM_CTRL_POR 5'h00
`define NVM_KEY_FIRST 8'h55
`define NVM_KEY_SECOND 8'haa
`define NVM_CFG_LOCK_BIT 7
`define NVM_MEM_DEPTH 64
`define NVM_MEM_AW 6
`define NVM_CLK_HZ 40000000
`define NVM_POWERUP_DELAY_TIMER_MS 72
`define NVM_POWERUP_DELAY_TIMER_CYCLES (`NVM_POWERUP_DELAY_TIMER_MS * (`NVM_CLK_HZ / 1000))
`define NVM_WRITE_US 4000
`define NVM_WRITE_CYCLES (`NVM_WRITE_US * (`NVM_CLK_HZ / 1000000))
`define NVM_TMR_W 22
`endif

// >>> inc/nvm_pkg.sv
// Types shared by the data EEPROM access controller.
package nvm_pkg;
   typedef enum logic [1:0] {
      NVM_UNLOCK_IDLE,
      NVM_UNLOCK_GOT_FIRST,
      NVM_UNLOCK_ARMED
   } nvm_unlock_state_type;
endpackage

// >>> logic/nvm_tick_timer.sv
// Down counter that measures a fixed number of clock cycles.
`include "nvm_params.svh"
module nvm_tick_timer
   import nvm_pkg::*;
#(
   parameter logic [`NVM_TMR_W-1:0] COUNT = 22'h000010
) (
   input wire logic i_ref_clk,
   input wire logic i_clr,
   input wire logic i_start,
   output logic o_busy,
   output logic o_done
);
   logic [`NVM_TMR_W-1:0] cnt_ff;
   logic [`NVM_TMR_W-1:0] nxt_cnt;

   always_comb begin
      nxt_cnt = cnt_ff;
      if (i_clr) begin
         nxt_cnt = '0;
      end else if (i_start) begin
         nxt_cnt = COUNT;
      end else if (cnt_ff != '0) begin
         nxt_cnt = cnt_ff - 1'b1;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      cnt_ff <= nxt_cnt;
   end

   assign o_busy = (cnt_ff != '0);
   assign o_done = (cnt_ff == {{(`NVM_TMR_W-1){1'b0}}, 1'b1}) && !i_clr;
endmodule

// >>> logic/nvm_unlock_seq.sv
// Tracker for the two-key unlock sequence ahead of a store.
`include "nvm_params.svh"
module nvm_unlock_seq
   import nvm_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic i_reg_wr,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   output logic o_armed
);
   nvm_unlock_state_type state_ff;
   nvm_unlock_state_type nxt_state;
   logic key_wr;

   assign key_wr = i_reg_wr && (i_reg_addr == `NVM_UNLOCK_OFS);

   // Every register write moves the tracker; only the exact order advances it.
   always_comb begin
      nxt_state = state_ff;
      if (i_reg_wr) begin
         nxt_state = NVM_UNLOCK_IDLE;
         unique case (state_ff)
            NVM_UNLOCK_IDLE: begin
               if (key_wr && i_reg_wdata == `NVM_KEY_FIRST) begin
                  nxt_state = NVM_UNLOCK_GOT_FIRST;
               end
            end
            NVM_UNLOCK_GOT_FIRST: begin
               if (key_wr && i_reg_wdata == `NVM_KEY_SECOND) begin
                  nxt_state = NVM_UNLOCK_ARMED;
               end else if (key_wr && i_reg_wdata == `NVM_KEY_FIRST) begin
                  nxt_state = NVM_UNLOCK_GOT_FIRST;
               end
            end
            NVM_UNLOCK_ARMED: begin
               if (key_wr && i_reg_wdata == `NVM_KEY_FIRST) begin
                  nxt_state = NVM_UNLOCK_GOT_FIRST;
               end
            end
            default: nxt_state = NVM_UNLOCK_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         state_ff <= NVM_UNLOCK_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign o_armed = (state_ff == NVM_UNLOCK_ARMED);
endmodule

// >>> logic/nvm_access_ctrl.sv
// Data EEPROM access controller with its four special function registers.
`include "nvm_params.svh"
module nvm_access_ctrl
   import nvm_pkg::*;
#(
   parameter logic [`NVM_TMR_W-1:0] POWERUP_DELAY_TIMER_CYCLES = `NVM_TMR_W'(`NVM_POWERUP_DELAY_TIMER_CYCLES),
   parameter logic [`NVM_TMR_W-1:0] WRITE_CYCLES = `NVM_TMR_W'(`NVM_WRITE_CYCLES)
) (
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic i_por_rst,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic [7:0] i_cfg_word,
   input wire logic i_code_protect,
   output logic [7:0] o_reg_rdata,
   output logic o_store_done_flag,
   output logic o_store_busy,
   output logic o_data_protected
);
   ////////////////////////////////////////////////////////////////////////////
   // Storage and registers.
   logic [7:0] mem [0:`NVM_MEM_DEPTH-1];
   logic [7:0] data_ff;
   logic [7:0] nxt_data;
   logic [7:0] addr_ff;
   logic [7:0] nxt_addr;
   logic [4:0] ctrl_ff;
   logic [4:0] nxt_ctrl;
   logic [7:0] wr_data_ff;
   logic [7:0] nxt_wr_data;
   logic [`NVM_MEM_AW-1:0] wr_addr_ff;
   logic [`NVM_MEM_AW-1:0] nxt_wr_addr;
   logic wr_valid_ff;
   logic nxt_wr_valid;
   logic [7:0] rdata_ff;
   logic [7:0] nxt_rdata;
   logic done_out_ff;
   logic busy_out_ff;
   logic prot_ff;

   logic armed;
   logic powerup_delay_timer_busy;
   logic wr_busy;
   logic wr_done;
   logic ctrl_wr;
   logic go_ok;
   logic addr_in_range;
   logic [7:0] mem_rd;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers.
   nvm_unlock_seq u_unlock (
      .i_ref_clk(i_ref_clk),
      .i_sys_rst(i_sys_rst),
      .i_reg_wr(i_reg_wr),
      .i_reg_addr(i_reg_addr),
      .i_reg_wdata(i_reg_wdata),
      .o_armed(armed)
   );

   // Power-up delay timer restarts only on power-on reset.
   nvm_tick_timer #(.COUNT(POWERUP_DELAY_TIMER_CYCLES)) u_powerup_delay_timer (
      .i_ref_clk(i_ref_clk),
      .i_clr(1'b0),
      .i_start(i_por_rst),
      .o_busy(powerup_delay_timer_busy),
      .o_done()
   );

   // Self-timed erase-and-program cycle.
   nvm_tick_timer #(.COUNT(WRITE_CYCLES)) u_wr_tmr (
      .i_ref_clk(i_ref_clk),
      .i_clr(i_sys_rst),
      .i_start(go_ok),
      .o_busy(wr_busy),
      .o_done(wr_done)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Control decode.
   assign ctrl_wr = i_reg_wr && (i_reg_addr == `NVM_CTRL_OFS);
   assign addr_in_range = (addr_ff[7:6] == 2'b00);
   assign mem_rd = addr_in_range ? mem[addr_ff[`NVM_MEM_AW-1:0]] : 8'h00;

   // Start needs keys, permit, idle engine, expired power-up delay.
   assign go_ok = ctrl_wr && i_reg_wdata[`NVM_BIT_GO] && armed
      && ctrl_ff[`NVM_BIT_PERMIT]
      && !powerup_delay_timer_busy
      && !ctrl_ff[`NVM_BIT_GO] && !i_sys_rst;

   always_comb begin
      nxt_ctrl = ctrl_ff;
      nxt_data = data_ff;
      nxt_addr = addr_ff;
      nxt_wr_data = wr_data_ff;
      nxt_wr_addr = wr_addr_ff;
      nxt_wr_valid = 1'b0;
      if (i_sys_rst) begin
         if (i_por_rst) begin
            nxt_ctrl = `NVM_CTRL_POR;
         end else begin
            // Abort flag keeps its value unless a store is cut short.
            nxt_ctrl[`NVM_BIT_DONE] = 1'b0;
            nxt_ctrl[`NVM_BIT_PERMIT] = 1'b0;
            nxt_ctrl[`NVM_BIT_GO] = 1'b0;
            nxt_ctrl[`NVM_BIT_FETCH] = 1'b0;
            if (wr_busy) begin
               nxt_ctrl[`NVM_BIT_ABORT] = 1'b1;
            end
         end
      end else begin
         if (i_reg_wr && i_reg_addr == `NVM_DATA_OFS) begin
            nxt_data = i_reg_wdata;
         end
         if (i_reg_wr && i_reg_addr == `NVM_ADDR_OFS) begin
            nxt_addr = i_reg_wdata;
         end
         if (ctrl_wr) begin
            nxt_ctrl[`NVM_BIT_DONE] = i_reg_wdata[`NVM_BIT_DONE];
            nxt_ctrl[`NVM_BIT_ABORT] = i_reg_wdata[`NVM_BIT_ABORT];
            nxt_ctrl[`NVM_BIT_PERMIT] = i_reg_wdata[`NVM_BIT_PERMIT];
            if (i_reg_wdata[`NVM_BIT_FETCH] && !ctrl_ff[`NVM_BIT_FETCH]) begin
               nxt_ctrl[`NVM_BIT_FETCH] = 1'b1;
            end
         end
         if (go_ok) begin
            nxt_ctrl[`NVM_BIT_GO] = 1'b1;
            nxt_wr_data = data_ff;
            nxt_wr_addr = addr_ff[`NVM_MEM_AW-1:0];
            nxt_wr_valid = 1'b0;
         end
         if (ctrl_ff[`NVM_BIT_FETCH]) begin
            nxt_data = mem_rd;
            nxt_ctrl[`NVM_BIT_FETCH] = 1'b0;
         end
         if (wr_done) begin
            nxt_ctrl[`NVM_BIT_GO] = 1'b0;
            nxt_ctrl[`NVM_BIT_DONE] = 1'b1;
            nxt_wr_valid = 1'b1;
         end
      end
   end

   always_ff @(posedge i_ref_clk) begin
      ctrl_ff <= nxt_ctrl;
      data_ff <= nxt_data;
      addr_ff <= nxt_addr;
      wr_data_ff <= nxt_wr_data;
      wr_addr_ff <= nxt_wr_addr;
      wr_valid_ff <= nxt_wr_valid;
   end

   // Cells are committed at the end of the timed cycle; out-of-range stores drop.
   logic wr_in_range_ff;
   logic nxt_wr_in_range;

   always_comb begin
      nxt_wr_in_range = wr_in_range_ff;
      if (go_ok) begin
         nxt_wr_in_range = addr_in_range;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      wr_in_range_ff <= nxt_wr_in_range;
      if (wr_valid_ff && wr_in_range_ff) begin
         mem[wr_addr_ff] <= wr_data_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read path and status outputs.
   always_comb begin
      nxt_rdata = rdata_ff;
      if (i_sys_rst) begin
         nxt_rdata = 8'h00;
      end else if (i_reg_rd) begin
         unique case (i_reg_addr)
            `NVM_DATA_OFS: nxt_rdata = data_ff;
            `NVM_ADDR_OFS: nxt_rdata = addr_ff;
            `NVM_CTRL_OFS: nxt_rdata = {3'b000, ctrl_ff};
            `NVM_UNLOCK_OFS: nxt_rdata = 8'h00;
            default: nxt_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge i_ref_clk) begin
      rdata_ff <= nxt_rdata;
      if (i_sys_rst) begin
         done_out_ff <= 1'b0;
         busy_out_ff <= 1'b0;
         prot_ff <= 1'b0;
      end else begin
         done_out_ff <= nxt_ctrl[`NVM_BIT_DONE];
         busy_out_ff <= nxt_ctrl[`NVM_BIT_GO];
         prot_ff <= ~i_cfg_word[`NVM_CFG_LOCK_BIT] && i_code_protect |
            ~i_cfg_word[`NVM_CFG_LOCK_BIT];
      end
   end

   assign o_reg_rdata = rdata_ff;
   assign o_store_done_flag = done_out_ff;
   assign o_store_busy = busy_out_ff;
   assign o_data_protected = prot_ff;
endmodule

// >>> sim/nvm_access_ctrl_asserts.sv
// Port checks for the data EEPROM access controller.
module nvm_access_ctrl_asserts #(
   parameter int WRITE_CYCLES = 8
) (
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic i_por_rst,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic [7:0] i_cfg_word,
   input wire logic i_code_protect,
   input wire logic [7:0] o_reg_rdata,
   input wire logic o_store_done_flag,
   input wire logic o_store_busy,
   input wire logic o_data_protected
);
   default clocking @(posedge i_ref_clk);
   endclocking
   default disable iff (i_sys_rst);
   wire logic ctl_wr = i_reg_wr && i_reg_addr == 8'h88;
   wire logic go_wr = ctl_wr && i_reg_wdata[1];
   wire logic hit = i_reg_addr inside {8'h08, 8'h09, 8'h88, 8'h89};
   int run_ff;
   int nxt_run;
   always_comb nxt_run = o_store_busy ? run_ff + 1 : 0;
   always_ff @(posedge i_ref_clk) run_ff <= i_sys_rst ? 0 : nxt_run;
   sequence s_rd(a);
      i_reg_rd && i_reg_addr == a;
   endsequence
   a_unlock_reads_zero: assert property (s_rd(8'h89) |=> o_reg_rdata == 8'h00)
      else $error("unlock port read not zero");
   a_unmapped_zero: assert property (i_reg_rd && !hit |=> o_reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_ctrl_top_zero: assert property (s_rd(8'h88) |=> o_reg_rdata[7:5] == 3'h0)
      else $error("control upper bits set");
   a_start_needs_go: assert property ($rose(o_store_busy) |-> $past(go_wr))
      else $error("store began without go write");
   a_done_at_end: assert property ($fell(o_store_busy) |-> o_store_done_flag)
      else $error("done flag missing at store end");
   a_done_sticky: assert property (o_store_done_flag && !ctl_wr && !$past(ctl_wr)
      |=> o_store_done_flag)
      else $error("done flag cleared by hardware");
   a_store_length: assert property ($fell(o_store_busy) |->
      run_ff >= WRITE_CYCLES - 1 && run_ff <= WRITE_CYCLES + 1)
      else $error("store length wrong");
   a_rdata_holds: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
      else $error("read data changed without read");
   a_protect_flag: assert property (!$past(i_sys_rst) |->
      o_data_protected == !$past(i_cfg_word[7]))
      else $error("protect flag wrong");
endmodule
bind nvm_access_ctrl nvm_access_ctrl_asserts #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (
   .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_por_rst(i_por_rst), .i_reg_wr(i_reg_wr),
   .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
   .i_cfg_word(i_cfg_word), .i_code_protect(i_code_protect), .o_reg_rdata(o_reg_rdata),
   .o_store_done_flag(o_store_done_flag), .o_store_busy(o_store_busy),
   .o_data_protected(o_data_protected));

// >>> sim/nvm_cpu_model.sv
// CPU side model issuing register reads and writes.
module nvm_cpu_model (
   input wire logic i_ref_clk,
   input wire logic [7:0] i_rdata,
   output logic o_wr,
   output logic o_rd,
   output logic [7:0] o_addr,
   output logic [7:0] o_wdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_addr = 8'h00;
      o_wdata = 8'h00;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_ref_clk);
      o_wr = 1'b1;
      o_addr = a;
      o_wdata = d;
      @(negedge i_ref_clk);
      o_wr = 1'b0;
      o_addr = ~a;
      o_wdata = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge i_ref_clk);
      o_rd = 1'b1;
      o_addr = a;
      @(negedge i_ref_clk);
      o_rd = 1'b0;
      o_addr = ~a;
      d = i_rdata;
   endtask
endmodule

// >>> sim/data_eeprom_access_control_tb.sv
// Self-checking bench for the data EEPROM access controller.
module data_eeprom_access_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst, por, cp, wr, rd, done, busy, prot;
   logic [7:0] cfg, rdata, addr, wdata, got;
   int err_total = 0;
   int check_count = 0;
   nvm_cpu_model CPU (.i_ref_clk(clk), .i_rdata(rdata), .o_wr(wr), .o_rd(rd), .o_addr(addr),
      .o_wdata(wdata));
   nvm_access_ctrl #(.POWERUP_DELAY_TIMER_CYCLES(22'h000014), .WRITE_CYCLES(22'h000008)) DUT (
      .i_ref_clk(clk), .i_sys_rst(rst), .i_por_rst(por), .i_reg_wr(wr), .i_reg_rd(rd),
      .i_reg_addr(addr), .i_reg_wdata(wdata), .i_cfg_word(cfg), .i_code_protect(cp),
      .o_reg_rdata(rdata), .o_store_done_flag(done), .o_store_busy(busy),
      .o_data_protected(prot));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic chk(input logic [7:0] act, input logic [7:0] exp);
      check_count++;
      if (act !== exp) begin
         err_total++;
         $display("[ERR] %0t got %h want %h", $time, act, exp);
      end
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] exp);
      CPU.rd(a, got);
      chk(got, exp);
   endtask
   task automatic final_report;
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Back-to-back writes, so no interrupt can split the keys.
   task automatic go(input logic [7:0] p, input logic [7:0] k1, input logic [7:0] k2);
      CPU.wr(8'h88, p);
      CPU.wr(8'h89, k1);
      CPU.wr(8'h89, k2);
      CPU.wr(8'h88, p | 8'h02);
   endtask
   task automatic t_powerup;
      rc(8'h88, 8'h00);
      go(8'h04, 8'h55, 8'haa);
      rc(8'h88, 8'h04);
      chk({7'h00, prot}, 8'h01);
      cfg = 8'hff;
      repeat (30) @(negedge clk);
      chk({7'h00, prot}, 8'h00);
      $display("powerup done");
   endtask
   task automatic t_store(input logic [7:0] a, input logic [7:0] d, input logic mid);
      CPU.wr(8'h09, a);
      CPU.wr(8'h08, d);
      go(8'h04, 8'h55, 8'haa);
      rc(8'h88, 8'h06);
      chk({7'h00, busy}, 8'h01);
      if (mid) CPU.wr(8'h88, 8'h00);
      for (int n = 0; n < 40 && done !== 1'b1; n++)
         @(negedge clk);
      chk({7'h00, done}, 8'h01);
      chk({7'h00, busy}, 8'h00);
      rc(8'h88, mid ? 8'h10 : 8'h14);
      CPU.wr(8'h88, 8'h00);
      rc(8'h88, 8'h00);
      CPU.wr(8'h08, ~d);
      CPU.wr(8'h88, 8'h01);
      rc(8'h08, d);
      $display("store %h done", a);
   endtask
   task automatic t_refuse;
      go(8'h04, 8'haa, 8'h55);
      rc(8'h88, 8'h04);
      CPU.wr(8'h89, 8'h55);
      CPU.wr(8'h09, 8'h00);
      CPU.wr(8'h89, 8'haa);
      CPU.wr(8'h88, 8'h06);
      rc(8'h88, 8'h04);
      go(8'h00, 8'h55, 8'haa);
      rc(8'h88, 8'h00);
      rc(8'h89, 8'h00);
      rc(8'h8a, 8'h00);
      CPU.wr(8'h09, 8'h40);
      CPU.wr(8'h88, 8'h01);
      rc(8'h08, 8'h00);
      $display("refuse done");
   endtask
   task automatic t_abort;
      CPU.wr(8'h09, 8'h2a);
      CPU.wr(8'h08, 8'h3c);
      go(8'h04, 8'h55, 8'haa);
      repeat (3) @(negedge clk);
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      rc(8'h88, 8'h08);
      rc(8'h08, 8'h3c);
      rc(8'h09, 8'h2a);
      $display("abort done");
   endtask
   initial begin
      rst = 1'b1;
      por = 1'b1;
      cfg = 8'h7f;
      cp = 1'b1;
      repeat (8) @(negedge clk);
      rst = 1'b0;
      por = 1'b0;
      t_powerup;
      t_store(8'h00, 8'ha5, 1'b0);
      t_store(8'h3f, 8'h5a, 1'b1);
      t_refuse;
      t_abort;
      final_report;
   end
   initial begin
      #50us;
      err_total++;
      $display("[ERR] %0t watchdog expired", $time);
      final_report;
   end
endmodule
